// ==== rtl/serial_port_defs.svh ====
`ifndef SERIAL_PORT_DEFS_SVH
`define SERIAL_PORT_DEFS_SVH
// ------------------------------------------------------------
// register offsets (byte addresses, one word each)
// ------------------------------------------------------------
`define ADDR_FMT      4'h0
`define ADDR_TXHOLD   4'h4
`define ADDR_FLAGS    4'h8
`define ADDR_RXDATA   4'hC
`define ADDR_BITDIV   5'h10
// ------------------------------------------------------------
// fields and reset values
// ------------------------------------------------------------
`define FMT_SYNC      7
`define FMT_CHR7      6
`define FMT_PAR_EN    5
`define FMT_PAR_ODD   4
`define FMT_STOP2     3
`define FMT_MP        2
`define FLG_TX_EMPTY  7
`define FLG_RX_FULL   6
`define FLG_PAR_ERR   3
`define FLG_FRM_ERR   4
`define FLG_TX_END    2
`define FLG_MPB       1
`define FLG_TX_EN     0
`define RST_FMT       8'h00
`define RST_TXHOLD    8'hFF
`define RST_RXDATA    8'h00
`define RST_BITDIV    8'h0F
`endif

// ==== rtl/serial_port_pkg.sv ====
package serial_port_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [4:0] addr_t;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_DATA,
    ST_PAR,
    ST_STOP
  } frame_st_e;
endpackage

// ==== rtl/serial_port_unit.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_defs.svh"
module serial_port_unit (
  input  wire logic                  core_clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  standby_i,
  input  wire serial_port_pkg::addr_t addr_i,
  input  wire serial_port_pkg::byte_t wdata_i,
  input  wire logic                  wr_i,
  input  wire logic                  rd_i,
  input  wire logic                  rxd_i,
  output logic [7:0]                 rdata_o,
  output logic                       txd_o,
  output logic                       sck_o
);
  import serial_port_pkg::*;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  byte_t     fmt_r, txhold_r, rxdata_r, bitdiv_r;
  logic      tx_empty_r, rx_full_r, par_err_r, frm_err_r, tx_end_r, mpb_r, tx_en_r;
  logic      clr;
  logic      tx_load, rx_done, tx_end_set;
  logic      rx_perr, rx_ferr, rx_mpb;
  assign clr = rst_i | standby_i;

  function automatic logic sel(input addr_t a, input addr_t off);
    return a == off;
  endfunction

  logic wfmt, wtx, wflg;
  assign wfmt = wr_i && sel(addr_i, 5'(`ADDR_FMT));
  assign wtx  = wr_i && sel(addr_i, 5'(`ADDR_TXHOLD));
  assign wflg = wr_i && sel(addr_i, 5'(`ADDR_FLAGS));

  logic sync_m, chr7, par_on, stop2, mp_on;
  assign sync_m = fmt_r[`FMT_SYNC];
  assign chr7   = !sync_m && fmt_r[`FMT_CHR7];
  assign mp_on  = !sync_m && fmt_r[`FMT_MP];
  assign par_on = !sync_m && !mp_on && fmt_r[`FMT_PAR_EN];
  assign stop2  = fmt_r[`FMT_STOP2];

  always_ff @(posedge core_clk_i) begin
    if (clr) begin
      fmt_r <= `RST_FMT;
    end else if (wfmt) begin
      fmt_r <= wdata_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (clr) begin
      txhold_r <= `RST_TXHOLD;
    end else if (wtx) begin
      txhold_r <= wdata_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (clr) begin
      bitdiv_r <= `RST_BITDIV;
    end else if (wr_i && sel(addr_i, `ADDR_BITDIV)) begin
      bitdiv_r <= wdata_i;
    end
  end

  // flags: set wins over clear; writing 1 never sets a status flag (tx_en_r takes the written value)
  always_ff @(posedge core_clk_i) begin
    if (clr) begin
      tx_empty_r <= 1'b1;
      tx_end_r   <= 1'b1;
      rx_full_r  <= 1'b0;
      par_err_r  <= 1'b0;
      frm_err_r  <= 1'b0;
      mpb_r      <= 1'b0;
      tx_en_r    <= 1'b0;
    end else begin
      if (wflg) begin
        tx_en_r <= wdata_i[`FLG_TX_EN];
      end
      if (tx_load || !tx_en_r) begin
        tx_empty_r <= 1'b1;
      end else if (wflg && !wdata_i[`FLG_TX_EMPTY]) begin
        tx_empty_r <= 1'b0;
      end
      if (tx_end_set) begin
        tx_end_r <= 1'b1;
      end else if (tx_load || (wflg && !wdata_i[`FLG_TX_EMPTY])) begin
        tx_end_r <= 1'b0;
      end
      if (rx_done) begin
        rx_full_r <= 1'b1;
        par_err_r <= par_err_r | rx_perr;
        frm_err_r <= frm_err_r | rx_ferr;
        mpb_r     <= rx_mpb;
      end else if (wflg) begin
        rx_full_r <= rx_full_r & wdata_i[`FLG_RX_FULL];
        par_err_r <= par_err_r & wdata_i[`FLG_PAR_ERR];
        frm_err_r <= frm_err_r & wdata_i[`FLG_FRM_ERR];
      end
    end
  end

  // ------------------------------------------------------------
  // read port
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        5'(`ADDR_FMT):    rdata_o <= fmt_r;
        5'(`ADDR_TXHOLD): rdata_o <= txhold_r;
        5'(`ADDR_RXDATA): rdata_o <= rxdata_r;
        5'(`ADDR_BITDIV): rdata_o <= bitdiv_r;
        5'(`ADDR_FLAGS):  rdata_o <= {tx_empty_r, rx_full_r, 1'b0, frm_err_r, par_err_r,
                                      tx_end_r, mpb_r, tx_en_r};
        default:          rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // ------------------------------------------------------------
  // baud generator: prescaler then bit divider (16x oversample async)
  // ------------------------------------------------------------
  logic [5:0] pre_r;
  logic       pre_tick, tick16;
  logic [7:0] div_r;
  always_ff @(posedge core_clk_i) begin
    if (clr) begin
      pre_r <= 6'h00;
    end else begin
      pre_r <= pre_r + 6'h01;
    end
  end
  always_comb begin
    case (fmt_r[1:0])
      2'b00:   pre_tick = 1'b1;
      2'b01:   pre_tick = pre_r[1:0] == 2'b11;
      2'b10:   pre_tick = pre_r[3:0] == 4'hF;
      default: pre_tick = pre_r == 6'h3F;
    endcase
  end
  always_ff @(posedge core_clk_i) begin
    if (clr) begin
      div_r <= 8'h00;
    end else if (pre_tick) begin
      div_r <= (div_r >= bitdiv_r) ? 8'h00 : div_r + 8'h01;
    end
  end
  assign tick16 = pre_tick && (div_r >= bitdiv_r);

  // ------------------------------------------------------------
  // transmitter
  // ------------------------------------------------------------
  frame_st_e  tst_r;
  byte_t      tsr_r;
  logic [3:0] tph_r, tbit_r;
  logic       tpar_r, tbit_end;
  assign tbit_end = tick16 && (sync_m || tph_r == 4'hF);
  assign tx_load  = tx_en_r && !tx_empty_r && tbit_end &&
                    (tst_r == ST_IDLE ||
                     (tst_r == ST_STOP && (!stop2 || tbit_r == 4'd1)) ||
                     (sync_m && tst_r == ST_DATA && tbit_r == 4'd7));
  assign tx_end_set = tbit_end && tx_empty_r &&
                      ((tst_r == ST_STOP && (!stop2 || tbit_r == 4'd1)) ||
                       (sync_m && tst_r == ST_DATA && tbit_r == 4'd7));

  always_ff @(posedge core_clk_i) begin
    if (clr) begin
      tst_r  <= ST_IDLE;
      tsr_r  <= 8'hFF;
      tph_r  <= 4'h0;
      tbit_r <= 4'h0;
      tpar_r <= 1'b0;
      txd_o  <= 1'b1;
      sck_o  <= 1'b1;
    end else begin
      if (tick16) begin
        tph_r <= tph_r + 4'h1;
        sck_o <= !(sync_m && tst_r == ST_DATA) || tph_r[0];
      end
      if (tx_load) begin
        tsr_r  <= chr7 ? {1'b0, txhold_r[6:0]} : txhold_r;
        tpar_r <= fmt_r[`FMT_PAR_ODD];
        tbit_r <= 4'h0;
        tph_r  <= 4'h0;
        tst_r  <= sync_m ? ST_DATA : ST_START;
        txd_o  <= sync_m ? txhold_r[0] : 1'b0;
      end else if (tbit_end) begin
        case (tst_r)
          ST_START: begin
            tst_r <= ST_DATA;
            txd_o <= tsr_r[0];
          end
          ST_DATA: begin
            tpar_r <= tpar_r ^ tsr_r[0];
            tsr_r  <= {1'b1, tsr_r[7:1]};
            tbit_r <= tbit_r + 4'h1;
            if (tbit_r == (chr7 ? 4'd6 : 4'd7)) begin
              tbit_r <= 4'h0;
              tst_r  <= sync_m ? ST_IDLE : ((par_on || mp_on) ? ST_PAR : ST_STOP);
              txd_o  <= sync_m ? 1'b1 : (mp_on ? 1'b0 : (par_on ? tpar_r ^ tsr_r[0] : 1'b1));
            end else begin
              txd_o <= tsr_r[1];
            end
          end
          ST_PAR: begin
            tst_r <= ST_STOP;
            txd_o <= 1'b1;
          end
          ST_STOP: begin
            if (stop2 && tbit_r == 4'd0) begin
              tbit_r <= 4'd1;
            end else begin
              tst_r <= ST_IDLE;
            end
            txd_o <= 1'b1;
          end
          default: tst_r <= ST_IDLE;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // receiver (async, 16x oversampled; sync uses tick16 as bit clock)
  // ------------------------------------------------------------
  frame_st_e  rst_st_r;
  byte_t      rsr_r;
  logic [3:0] rph_r, rbit_r;
  logic       rpar_r, rsamp;
  assign rsamp = tick16 && (sync_m || rph_r == 4'h7);
  assign rx_done = rsamp && ((rst_st_r == ST_STOP) ||
                   (sync_m && rst_st_r == ST_DATA && rbit_r == 4'd7));
  assign rx_ferr = !sync_m && !rxd_i;
  assign rx_perr = par_on && rpar_r;
  assign rx_mpb  = mp_on && rpar_r;

  always_ff @(posedge core_clk_i) begin
    if (clr) begin
      rst_st_r <= ST_IDLE;
      rsr_r    <= 8'h00;
      rph_r    <= 4'h0;
      rbit_r   <= 4'h0;
      rpar_r   <= 1'b0;
    end else begin
      if (tick16) begin
        rph_r <= rph_r + 4'h1;
      end
      case (rst_st_r)
        ST_IDLE: begin
          if (tick16 && !rxd_i) begin
            rst_st_r <= sync_m ? ST_DATA : ST_START;
            rph_r    <= 4'h1;
            rbit_r   <= 4'h0;
            rpar_r   <= fmt_r[`FMT_PAR_ODD];
            if (sync_m) begin
              rsr_r  <= {rxd_i, 7'h00};
              rbit_r <= 4'h1;
            end
          end
        end
        ST_START: begin
          if (rsamp) begin
            rst_st_r <= rxd_i ? ST_IDLE : ST_DATA;
          end
        end
        ST_DATA: begin
          if (rsamp) begin
            rsr_r  <= chr7 && rbit_r == 4'd6 ? {1'b0, rxd_i, rsr_r[7:2]} :
                      {rxd_i, rsr_r[7:1]};
            rpar_r <= rpar_r ^ rxd_i;
            rbit_r <= rbit_r + 4'h1;
            if (rbit_r == (chr7 ? 4'd6 : 4'd7)) begin
              rst_st_r <= sync_m ? ST_IDLE : ((par_on || mp_on) ? ST_PAR : ST_STOP);
            end
          end
        end
        ST_PAR: begin
          if (rsamp) begin
            rpar_r   <= mp_on ? rxd_i : rpar_r ^ rxd_i ^ 1'b0;
            rst_st_r <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (rsamp) begin
            rst_st_r <= ST_IDLE;
          end
        end
        default: rst_st_r <= ST_IDLE;
      endcase
    end
  end

  // rx parity: odd sense seeds 1, so a residual 1 means a mismatch
  always_ff @(posedge core_clk_i) begin
    if (clr) begin
      rxdata_r <= `RST_RXDATA;
    end else if (rx_done) begin
      rxdata_r <= sync_m ? {rxd_i, rsr_r[7:1]} : rsr_r;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  chk_txhold_reset: assert property (@(posedge core_clk_i) clr |=> txhold_r == 8'hFF)
    else $error("holding buffer not all ones after clear");
  chk_rxdata_ro: assert property (@(posedge core_clk_i) disable iff (clr)
    !rx_done |=> rxdata_r == $past(rxdata_r))
    else $error("receive buffer changed without a received byte");
  chk_fmt_reset: assert property (@(posedge core_clk_i) clr |=> fmt_r == 8'h00)
    else $error("format register not cleared");
  chk_empty_on_load: assert property (@(posedge core_clk_i) disable iff (clr)
    tx_load |=> tx_empty_r)
    else $error("empty flag not set on load");
  chk_no_load_empty: assert property (@(posedge core_clk_i) disable iff (clr)
    (tx_empty_r && tst_r == ST_IDLE) |=> tst_r == ST_IDLE)
    else $error("transmitter left idle while empty flag set");
  chk_chr7_msb: assert property (@(posedge core_clk_i) disable iff (clr)
    (tx_load && chr7) |=> !tsr_r[7])
    else $error("seven-bit load kept holding buffer bit 7");
  chk_start_bit: assert property (@(posedge core_clk_i) disable iff (clr)
    (tx_load && !sync_m) |=> !txd_o && tst_r == ST_START)
    else $error("start bit not zero");
  chk_one_no_set: assert property (@(posedge core_clk_i) disable iff (clr)
    (wflg && wdata_i[`FLG_RX_FULL] && !rx_full_r && !rx_done) |=> !rx_full_r)
    else $error("flag set by writing one");
  chk_stop_high: assert property (@(posedge core_clk_i) disable iff (clr)
    tst_r == ST_STOP |-> txd_o)
    else $error("stop bit not one");
  chk_clear_start: assert property (@(posedge core_clk_i) disable iff (clr)
    (wflg && !wdata_i[`FLG_TX_EMPTY] && tx_en_r && !tx_load && wdata_i[`FLG_TX_EN])
    |=> !tx_empty_r)
    else $error("clearing empty flag did not arm transmit");
  cov_tx_load: cover property (@(posedge core_clk_i) tx_load);
  cov_rx_done: cover property (@(posedge core_clk_i) rx_done);
  cov_sync_tx: cover property (@(posedge core_clk_i) tx_load && sync_m);
  cov_par_err: cover property (@(posedge core_clk_i) rx_done && rx_perr);
  cov_mp_rx: cover property (@(posedge core_clk_i) rx_done && rx_mpb);
endmodule
`default_nettype wire

// ==== test/remote_serial.sv ====
`timescale 1ns/1ps
`default_nettype none
module remote_serial (
  input  wire logic core_clk_i,
  input  wire logic txd_i,
  output logic      rxd_o
);
  int          bit_clks = 16;
  int          rx_len   = 9;
  logic [15:0] got_q[$];

  initial rxd_o = 1'b1;

  // ---------
  // far receiver: mid-bit sampling
  // ---------
  always begin : take
    logic [15:0] w;
    @(negedge txd_i);
    w = '0;
    repeat (bit_clks / 2) @(posedge core_clk_i);
    for (int i = 0; i < rx_len; i++) begin
      repeat (bit_clks) @(posedge core_clk_i);
      w[i] = txd_i;
    end
    got_q.push_back(w);
  end

  // ---------
  // far sender: line keeps the level of the last bit sent
  // ---------
  task automatic send(input logic [15:0] b, input int n);
    rxd_o <= 1'b0;
    repeat (bit_clks) @(posedge core_clk_i);
    for (int i = 0; i < n; i++) begin
      rxd_o <= b[i];
      repeat (bit_clks) @(posedge core_clk_i);
    end
  endtask
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import serial_port_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst      = 1'b1;
  logic        standby  = 1'b0;
  addr_t       addr     = '0;
  byte_t       wdata    = '0;
  logic        wr       = 1'b0;
  logic        rd       = 1'b0;
  logic        rxd;
  logic [7:0]  rdata;
  logic        txd;
  logic        sck;
  int          errors   = 0;
  int          n_tests  = 0;
  int          sck_low  = 0;
  int          s;
  int          k;
  int          n;
  byte_t       v;
  logic [15:0] e;
  logic [15:0] m;

  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) if (sck === 1'b0) sck_low <= sck_low + 1;

  serial_port_unit dut (.core_clk_i(core_clk), .rst_i(rst), .standby_i(standby),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rxd_i(rxd),
    .rdata_o(rdata), .txd_o(txd), .sck_o(sck));
  remote_serial far (.core_clk_i(core_clk), .txd_i(txd), .rxd_o(rxd));

  // ---------
  // bus access and compares
  // ---------
  task automatic wr_reg(input addr_t a, input byte_t d);
    @(posedge core_clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input addr_t a, output byte_t d);
    @(posedge core_clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic chk_reg(input string t, input byte_t ex, input byte_t got);
    n_tests++;
    if (got !== ex) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", t, ex, got);
    end
  endtask
  task automatic chk_line(input string t, input logic [15:0] ex, input logic [15:0] got);
    n_tests++;
    if (got !== ex) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", t, ex, got);
    end
  endtask
  task automatic rd_chk(input addr_t a, input byte_t ex, input string t);
    rd_reg(a, v);
    chk_reg(t, ex, v);
  endtask
  task automatic rd_flag(input int b, input logic ex, input string t);
    rd_reg(5'h08, v);
    chk_reg(t, {7'h0, ex}, {7'h0, v[b]});
  endtask
  task automatic wait_q(input int c);
    for (int i = 0; i < 30000 && far.got_q.size() < c; i++) @(posedge core_clk);
    chk_line("frame count", 16'(c), 16'(far.got_q.size()));
  endtask
  task automatic start_tx(input byte_t d);
    wr_reg(5'h08, 8'h81);
    wr_reg(5'h04, d);
    wr_reg(5'h08, 8'h01);
  endtask
  function automatic logic [15:0] frame(input byte_t f, input byte_t d, output int c,
                                        output logic [15:0] mk);
    logic [15:0] x;
    x  = '0;
    mk = '1;
    c  = f[6] ? 7 : 8;
    for (int i = 0; i < c; i++) x[i] = d[i];
    if (f[2]) begin
      mk[c] = 1'b0;
      c++;
    end else if (f[5]) begin
      x[c] = ^x ^ f[4];
      c++;
    end
    x[c] = 1'b1;
    c++;
    if (f[3]) begin
      x[c] = 1'b1;
      c++;
    end
    mk = mk & ((16'h1 << c) - 16'h1);
    return x;
  endfunction
  task automatic tx_case(input byte_t f, input byte_t d);
    e = frame(f, d, n, m);
    far.rx_len = n;
    wr_reg(5'h00, f);
    start_tx(d);
    wait_q(1);
    chk_line("tx frame", e & m, far.got_q.pop_front() & m);
  endtask
  task automatic rx_case(input byte_t f, input logic [15:0] b, input int nb, input byte_t ex,
                         input logic pe);
    wr_reg(5'h00, f);
    wr_reg(5'h08, 8'h81);
    @(posedge core_clk);
    far.send(b, nb);
    repeat (16) @(posedge core_clk);
    rd_chk(5'h0C, ex, "rx data");
    rd_flag(3, pe, "parity err");
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (80000) @(posedge core_clk);
    errors++;
    print_verdict();
  end

  // ---------
  // tests
  // ---------
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    rd_chk(5'h00, 8'h00, "format");
    rd_chk(5'h04, 8'hff, "holding");
    rd_chk(5'h0C, 8'h00, "rx data");
    rd_chk(5'h14, 8'h00, "unmapped");
    wr_reg(5'h0C, 8'h55);
    rd_chk(5'h0C, 8'h00, "rx write");
    wr_reg(5'h00, 8'h3b);
    rd_chk(5'h00, 8'h3b, "format rw");
    wr_reg(5'h04, 8'h12);
    rd_chk(5'h04, 8'h12, "holding rw");
    @(posedge core_clk);
    standby <= 1'b1;
    @(posedge core_clk);
    standby <= 1'b0;
    rd_chk(5'h00, 8'h00, "format standby");
    rd_chk(5'h04, 8'hff, "holding standby");
    $display("test registers done");
    wr_reg(5'h10, 8'h00);
    s = sck_low;
    tx_case(8'h00, 8'ha6);
    tx_case(8'h40, 8'h4a);
    tx_case(8'h20, 8'hb5);
    tx_case(8'h30, 8'hb5);
    tx_case(8'h08, 8'h3c);
    tx_case(8'h34, 8'h96);
    chk_line("sck async", 16'h0, 16'(sck_low - s));
    $display("test tx formats done");
    wr_reg(5'h00, 8'h00);
    far.rx_len = 9;
    start_tx(8'h11);
    for (int i = 0; i < 200; i++) begin
      rd_reg(5'h08, v);
      if (v[7] === 1'b1) break;
    end
    rd_flag(7, 1'b1, "tx empty");
    wr_reg(5'h04, 8'h22);
    wr_reg(5'h08, 8'h01);
    wait_q(2);
    chk_line("first frame", 16'h0111, far.got_q.pop_front());
    chk_line("second frame", 16'h0122, far.got_q.pop_front());
    repeat (400) @(posedge core_clk);
    chk_line("extra frames", 16'h0, 16'(far.got_q.size()));
    $display("test back to back done");
    for (int c = 0; c < 4; c++) begin
      far.bit_clks = 16 << (2 * c);
      wr_reg(5'h00, byte_t'(c));
      start_tx(8'hff);
      for (int i = 0; i < 3000 && txd !== 1'b0; i++) @(posedge core_clk);
      k = 0;
      while (txd === 1'b0 && k < 5000) begin
        @(posedge core_clk);
        k++;
      end
      chk_line("start width", 16'(16 << (2 * c)), 16'(k));
      wait_q(1);
      chk_line("tx frame", 16'h01ff, far.got_q.pop_front());
    end
    far.bit_clks = 16;
    $display("test prescale done");
    s = sck_low;
    wr_reg(5'h00, 8'hc0);
    start_tx(8'h5a);
    repeat (300) @(posedge core_clk);
    chk_line("sck sync", 16'h1, 16'(sck_low > s));
    far.got_q.delete();
    $display("test sync done");
    rx_case(8'h00, 16'h01a6, 9, 8'ha6, 1'b0);
    rd_flag(6, 1'b1, "rx full");
    rx_case(8'h40, 16'h00b5, 8, 8'h35, 1'b0);
    rx_case(8'h20, 16'h020f, 10, 8'h0f, 1'b0);
    rx_case(8'h30, 16'h020f, 10, 8'h0f, 1'b1);
    wr_reg(5'h08, 8'h09);
    rd_flag(3, 1'b1, "flag kept");
    wr_reg(5'h08, 8'h01);
    wr_reg(5'h08, 8'h09);
    rd_flag(3, 1'b0, "flag not set");
    rx_case(8'h34, 16'h03a5, 10, 8'ha5, 1'b0);
    rd_flag(1, 1'b1, "mp bit");
    wr_reg(5'h00, 8'h08);
    @(posedge core_clk);
    far.send(16'h013c, 9);
    far.send(16'h01c3, 9);
    repeat (16) @(posedge core_clk);
    rd_chk(5'h0C, 8'hc3, "rx second");
    rd_flag(4, 1'b0, "frame err");
    $display("test receive done");
    print_verdict();
  end
endmodule
`default_nettype wire
